// File: rtl/bsb_core.v
// Bit-set and relative-branch execution block with a Wishbone register port.
// Overview of operation
// - Bit-set opcode forces one bit high.
// - Access bit zero addresses the access bank.
// - Access bit one uses bank select register.
// - Extended set, access zero, f<=95: indexed.
// - Branch loads PC+2+2n over two cycles.
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "bsb_map.vh"
module bsb_core #(
  parameter MEM_AW = 12
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [31:0] adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg         busy_o,
  output reg  [20:0] pc_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0]  mem_r [0:(1<<MEM_AW)-1];
  reg        xinst_r;
  reg [15:0] instr_r;
  reg [3:0]  bank_select_reg_r;
  reg [11:0] fsr2_r;
  reg [1:0]  st_r;
  reg [1:0]  q_r;
  reg [11:0] ea_r;
  reg [7:0]  last_r;
  reg [31:0] rd_nxt;
  reg [1:0]  st_nxt;
  reg [1:0]  q_nxt;
  reg        busy_nxt;

  localparam [1:0] ST_IDLE      = `BSB_ST_IDLE;
  localparam [1:0] ST_EXEC      = `BSB_ST_EXEC;
  localparam [1:0] ST_JUMP_WAIT = `BSB_ST_JUMP_WAIT;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Byte k of data memory sits at the base plus 4k, so the window is 16 KiB wide.
  wire [31:0] mem_off = adr_i - `BSB_REG_MEM_BASE;
  wire        is_mem  = (adr_i >= `BSB_REG_MEM_BASE) && (mem_off[31:14] == 18'h00000);
  wire [11:0] mem_ix  = mem_off[13:2];
  wire        acc     = cyc_i & stb_i & ~ack_o;
  wire        wr      = acc & we_i & sel_i[0];
  // Program state only changes while idle, so a running instruction sees stable operands.
  wire        wr_idle = wr & (st_r == ST_IDLE);
  wire        go_req  = wr_idle & (adr_i == `BSB_REG_CTRL) & dat_i[`BSB_CTRL_GO_BIT];

  // ----------------------------------------------------------------
  // Address resolution
  // ----------------------------------------------------------------
  function [11:0] data_addr;
    input [15:0] ins;
    input [3:0]  bank;
    input        xi;
    input [11:0] fsr2;
    reg   [7:0]  f;
    begin
      f = ins[7:0];
      if (ins[8])
        data_addr = {bank, f};
      else if (xi && f <= `BSB_ILO_LIMIT)
        data_addr = fsr2 + {4'h0, f};
      else if (f < `BSB_ACC_SPLIT)
        data_addr = {`BSB_BANK_HI_ACC_LOW, f};
      else
        data_addr = {`BSB_BANK_HI_ACC_HIGH, f};
    end
  endfunction

  wire [11:0] ea_now = data_addr(instr_r, bank_select_reg_r, xinst_r, fsr2_r);
  wire [20:0] ofs2 = {{9{instr_r[10]}}, instr_r[10:0], 1'b0};

  // One-hot mask for the bit index field.
  function [7:0] bit_mask;
    input [2:0] idx;
    begin
      bit_mask = 8'h01 << idx;
    end
  endfunction

  // The counter still points at the current word when an instruction retires, so this adds 2 to move past it.
  function [20:0] next_pc;
    input [20:0] pc;
    begin
      next_pc = pc + 21'h000002;
    end
  endfunction

  wire is_bit_set = (instr_r[15:12] == `BSB_OP_BIT_SET_NIB);
  wire is_jump    = (instr_r[15:11] == `BSB_OP_REL_BRANCH_HI);
  wire last_q     = (q_r == `BSB_Q_PHASES);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    rd_nxt = 32'h00000000;
    if (is_mem)
      rd_nxt = {24'h000000, mem_r[mem_ix[MEM_AW-1:0]]};
    else case (adr_i)
      `BSB_REG_CTRL:  rd_nxt = {31'h0, xinst_r};
      `BSB_REG_INSTR: rd_nxt = {16'h0, instr_r};
      `BSB_REG_BANK:  rd_nxt = {28'h0, bank_select_reg_r};
      `BSB_REG_FSR2:  rd_nxt = {20'h0, fsr2_r};
      `BSB_REG_PC:    rd_nxt = {11'h0, pc_o};
      `BSB_REG_DATA:  rd_nxt = {24'h0, last_r};
      `BSB_REG_STAT:  rd_nxt = {12'h000, ea_r, 6'h00, st_r};
      default:        rd_nxt = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= acc;
      if (acc) begin
        dat_o <= rd_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program state registers
  // ----------------------------------------------------------------
  // Writes to program state are ignored while an instruction runs.
  always @(posedge clk_i) begin
    if (rst_i) begin
      xinst_r           <= 1'b0;
      instr_r           <= 16'h0000;
      bank_select_reg_r <= 4'h0;
      fsr2_r            <= 12'h000;
    end else if (wr_idle && !is_mem) begin
      case (adr_i)
        `BSB_REG_CTRL:  xinst_r <= dat_i[`BSB_CTRL_XINST_BIT];
        `BSB_REG_INSTR: instr_r <= dat_i[15:0];
        `BSB_REG_BANK:  bank_select_reg_r <= dat_i[3:0];
        `BSB_REG_FSR2:  fsr2_r <= dat_i[11:0];
        default:        ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: four Q phases per instruction cycle
  // ----------------------------------------------------------------
  always @* begin
    st_nxt   = st_r;
    q_nxt    = q_r;
    busy_nxt = busy_o;
    case (st_r)
      ST_IDLE: begin
        if (go_req) begin
          st_nxt   = ST_EXEC;
          q_nxt    = 2'h0;
          busy_nxt = 1'b1;
        end
      end
      ST_EXEC: begin
        q_nxt = q_r + 2'h1;
        if (last_q) begin
          if (is_jump) begin
            st_nxt = ST_JUMP_WAIT;
          end else begin
            st_nxt   = ST_IDLE;
            busy_nxt = 1'b0;
          end
        end
      end
      ST_JUMP_WAIT: begin
        // Second branch cycle is a forced no-operation while fetch refills.
        q_nxt = q_r + 2'h1;
        if (last_q) begin
          st_nxt   = ST_IDLE;
          busy_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt   = ST_IDLE;
        q_nxt    = 2'h0;
        busy_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_r   <= ST_IDLE;
      q_r    <= 2'h0;
      busy_o <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      q_r    <= q_nxt;
      busy_o <= busy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Data path: memory, operand latch and program counter
  // ----------------------------------------------------------------
  // Data memory is left uninitialised on reset to keep the array free of reset fan-out.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pc_o   <= 21'h000000;
      ea_r   <= 12'h000;
      last_r <= 8'h00;
    end else begin
      if (wr_idle && is_mem) begin
        mem_r[mem_ix[MEM_AW-1:0]] <= dat_i[7:0];
      end
      if (wr_idle && (adr_i == `BSB_REG_PC)) begin
        pc_o <= {dat_i[20:1], 1'b0};
      end
      if (st_r == ST_EXEC) begin
        if (q_r == 2'h0) begin
          ea_r <= ea_now;
        end
        if (q_r == 2'h1) begin
          last_r <= mem_r[ea_r[MEM_AW-1:0]];
        end
        if (last_q) begin
          if (is_bit_set) begin
            // No status flags exist here, so the write-back touches nothing else.
            mem_r[ea_r[MEM_AW-1:0]] <= last_r | bit_mask(instr_r[11:9]);
            pc_o <= next_pc(pc_o);
          end else if (is_jump) begin
            pc_o <= next_pc(pc_o) + ofs2;
          end else begin
            pc_o <= next_pc(pc_o);
          end
        end
      end
    end
  end
endmodule

// File: common/bsb_map.vh
// Constants for the bit-set and relative-branch execution block.
`ifndef BSB_MAP_VH
`define BSB_MAP_VH
`define BSB_OP_BIT_SET_NIB    4'h8
`define BSB_OP_REL_BRANCH_HI  5'h1a
`define BSB_ILO_LIMIT         8'h5f
`define BSB_ACC_SPLIT         8'h60
`define BSB_BANK_HI_ACC_LOW   4'h0
`define BSB_BANK_HI_ACC_HIGH  4'hf
`define BSB_REG_CTRL          32'h00000000
`define BSB_REG_INSTR         32'h00000004
`define BSB_REG_BANK          32'h00000008
`define BSB_REG_FSR2          32'h0000000c
`define BSB_REG_PC            32'h00000010
`define BSB_REG_DATA          32'h00000014
`define BSB_REG_STAT          32'h00000018
`define BSB_REG_MEM_BASE      32'h00001000
`define BSB_CTRL_XINST_BIT    0
`define BSB_CTRL_GO_BIT       1
`define BSB_ST_IDLE           2'h0
`define BSB_ST_EXEC           2'h1
`define BSB_ST_JUMP_WAIT      2'h2
`define BSB_Q_PHASES          2'h3
`endif

// File: test/bsb_core_chk.sv
// Port timing checker for the bit-set and branch block.
`timescale 1ns/1ps
module bsb_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        ack_o,
  input wire        busy_o,
  input wire [20:0] pc_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  AST_PC_EVEN: assert property (pc_o[0] == 1'b0)
    else $error("odd pc");
  AST_BUSY_MIN: assert property ($rose(busy_o) |-> busy_o [*4])
    else $error("busy short");
  AST_BUSY_MAX: assert property ($rose(busy_o) |-> ##[4:8] !busy_o)
    else $error("busy long");
  AST_BUSY_JUMP: assert property ($rose(busy_o) ##4 busy_o |-> busy_o [*4] ##1 !busy_o)
    else $error("branch length wrong");
  AST_PC_HOLD: assert property (!busy_o && !(cyc_i && stb_i) |=> $stable(pc_o))
    else $error("pc moved while idle");
endmodule
bind bsb_core bsb_chk CHK (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .busy_o(busy_o), .pc_o(pc_o));

// File: test/tb_top.sv
// Self-checking bench for the bit-set and branch block.
`timescale 1ns/1ps
`include "bsb_map.vh"
module tb_top;
  reg         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  reg  [31:0] adr_i = 0, dat_i = 0, rv, ea, ev, pcm;
  wire [31:0] dat_o;
  wire        ack_o, busy_o;
  wire [20:0] pc_o;
  integer     err_total = 0, checks = 0, seed = 72, i, j, f, b, a, x, n, k, q;
  bsb_core DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .busy_o(busy_o), .pc_o(pc_o));
  initial forever #2 clk_i = ~clk_i;
  task finish_test; begin
    $display("err %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  end endtask
  task cmp(input [31:0] g, e); begin
    checks = checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  end endtask
  task hang; begin
    if (j >= 20) begin
      err_total = err_total + 1;
      finish_test;
    end
  end endtask
  task bus(input w, input [31:0] ad, d); begin
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= ad;
    dat_i <= d;
    j = 0;
    do begin
      @(posedge clk_i);
      j = j + 1;
    end while (ack_o !== 1 && j < 20);
    rv = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    hang;
    @(posedge clk_i);
  end endtask
  task go(input [15:0] ins, input [31:0] len); begin
    bus(1, `BSB_REG_INSTR, ins);
    bus(1, `BSB_REG_CTRL, x + 2);
    for (j = 0; busy_o === 1 && j < 20; j = j + 1) @(posedge clk_i);
    hang;
    cmp(j + 1, len);
  end endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    pcm = $random(seed) & 'h1ffffe;
    bus(1, `BSB_REG_PC, pcm);
    x = 0;
    go(16'h0000, 4);
    pcm = pcm + 2;
    for (i = 0; i < 40; i = i + 1) begin
      f = i < 4 ? 94 + i : $random(seed) & 255;
      a = i < 4 ? 0 : $random(seed) & 1;
      x = i < 4 ? 1 : $random(seed) & 1;
      b = $random(seed) & 7;
      k = $random(seed) & 15;
      q = $random(seed) & 4095;
      ev = $random(seed) & 255;
      ea = a ? k * 256 + f : x && f < 96 ? (q + f) & 4095 : f < 96 ? f : 3840 + f;
      bus(1, `BSB_REG_BANK, k);
      bus(1, `BSB_REG_FSR2, q);
      bus(1, `BSB_REG_MEM_BASE + 4 * ea, ev);
      go({4'h8, b[2:0], a[0], f[7:0]}, 4);
      bus(0, `BSB_REG_MEM_BASE + 4 * ea, 0);
      cmp(rv, ev | 1 << b);
      n = i == 0 ? 1023 : i == 1 ? -1024 : $random(seed) % 1024;
      go({5'h1a, n[10:0]}, 8);
      pcm = (pcm + 4 + 2 * n) & 'h1fffff;
      bus(0, `BSB_REG_PC, 0);
      cmp(rv, pcm);
      cmp(pc_o, pcm);
    end
    finish_test;
  end
endmodule
